// ===== hdl/cnb_regs.svh
/*
 constants of the non-pipelined bus cycle sequencer: reset values of the pins,
 halt and shutdown byte enables, operand masks and cycle-definition codes.
 assumes it is included by cnb_pkg users with a plain `include.
*/
`ifndef CNB_REGS_SVH
`define CNB_REGS_SVH

`define CNB_RST_ADDR 30'h3fffffff
`define CNB_RST_BE_N 4'h0
`define CNB_HALT_BE_N 4'hb
`define CNB_SHUT_BE_N 4'he
`define CNB_MASK_BYTE 8'h01
`define CNB_MASK_WORD 8'h03
`define CNB_MASK_DWORD 8'h0f
`define CNB_MASK_ONE 8'h01
`define CNB_ADDR_ZERO 30'h00000000

// cycle definition {space, data_control, direction, lock_n}
`define CNB_RST_DEF 4'h5
`define CNB_DEF_INTA 4'h0
`define CNB_DEF_IORD 4'h5
`define CNB_DEF_IOWR 4'h7
`define CNB_DEF_CODE 4'h9
`define CNB_DEF_HALT 4'hb
`define CNB_DEF_LMRD 4'hc
`define CNB_DEF_MRD 4'hd
`define CNB_DEF_LMWR 4'he
`define CNB_DEF_MWR 4'hf

`endif

// ===== hdl/cnb_pkg.sv
/*
 types of the non-pipelined bus cycle sequencer: bus states, cycle types,
 operand sizes and the packed state records of both modules.
 assumes nothing beyond a SystemVerilog compiler.
*/
package cnb_pkg;

   typedef enum logic [3:0] {
      bs_idle = 4'h1,
      bs_addr = 4'h2,
      bs_xfer = 4'h4,
      bs_hold = 4'h8
   } cnb_bus_state_t;

   typedef enum logic [3:0] {
      ct_mem_rd = 4'h0,
      ct_mem_wr = 4'h1,
      ct_lmem_rd = 4'h2,
      ct_lmem_wr = 4'h3,
      ct_io_rd = 4'h4,
      ct_io_wr = 4'h5,
      ct_inta = 4'h6,
      ct_halt = 4'h7,
      ct_shut = 4'h8,
      ct_code_rd = 4'h9
   } cnb_cyc_t;

   typedef enum logic [1:0] {
      sz_byte = 2'h0,
      sz_word = 2'h1,
      sz_dword = 2'h2
   } cnb_size_t;

   typedef struct packed {
      logic [35:0] s1;
      logic [35:0] s2;
   } cnb_sync_state_t;

   typedef struct packed {
      cnb_bus_state_t bs;
      logic ph;
      logic busy;
      cnb_cyc_t typ;
      logic [1:0] off;
      logic sec;
      logic [29:0] adr;
      logic [7:0] msk;
      logic [3:0] ln;
      logic nar;
      logic [63:0] wdat;
      logic [63:0] rdat;
      logic wr_hold;
      logic na_seen;
      logic pipe;
      logic ads_n;
      logic [29:0] a;
      logic [3:0] be_n;
      logic [3:0] def;
      logic [31:0] dout;
      logic oe_n;
      logic grant;
      logic rsp_v;
      logic [31:0] rsp_d;
   } cnb_state_t;

endpackage

// ===== hdl/cnb_sync.sv
/*
 two-flop synchroniser for the 36 pin inputs of the bus sequencer.
 assumes the pins are asynchronous to clk_i; only s2 is read outside.
*/
`timescale 1ns/100ps
`default_nettype none

module cnb_sync
   import cnb_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [35:0] pins_i,
   output logic [35:0] pins_o
);

   cnb_sync_state_t st;
   cnb_sync_state_t next_st;

   always_comb begin
      next_st.s1 = pins_i;
      next_st.s2 = st.s1;
      if (sys_rst_i) begin
         next_st = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   assign pins_o = st.s2;

endmodule

`default_nettype wire

// ===== hdl/cnb_bus.sv
/*
 non-pipelined local bus cycle sequencer: takes operand requests, splits them
 into bus cycles, runs address, transfer, idle and hold states, two clk_i
 periods per bus state.
 assumes clk_i is the double-rate bus clock and all pins are asynchronous.
*/
// Contract
// - data bus is 32 bits, or 16 bits while narrow select is asserted
// - device drives data only in writes, system only in reads
// - every cycle starts with address strobe and fresh cycle definition
// - a cycle ends only on ready from the system
// - no pending request means idle, seen only as missing address strobes
// - a bus state lasts two double-rate clock periods, transfer needs two
// - address, definition and strobe become valid in phase one of address state
// - ready is ignored at the end of address state
// - read ready in transfer state captures data lines and ends cycle
// - write data is driven from phase two of address state
// - write data stays through phase one of the next state
// - transfer state repeats as wait state until ready is seen
// - four states; one address state, always followed by transfer state
// - unacknowledged transfer state without next address repeats transfer state
// - after ready go to address state if request pending, else idle
// - hold request, when grantable, enters hold state with hold grant
// - after reset and idle, cycles use non-pipelined address timing
// - address and definition stay valid through every wait state
// - bytes, words, double words at any alignment, split where needed
// - memory, locked, I/O, halt, shutdown and locked interrupt acknowledge cycles
// - cycle definition codes on space, data control, direction and lock
// - halt and shutdown drive address zero and fixed byte enables
// - next address sampled at phase one of transfer state, used in waits
`timescale 1ns/100ps
`default_nettype none
`include "cnb_regs.svh"

module cnb_bus
   import cnb_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire cnb_cyc_t req_type_i,
   input wire cnb_size_t req_size_i,
   input wire logic [31:0] req_addr_i,
   input wire logic [31:0] req_wdata_i,
   output logic rsp_valid_o,
   output logic [31:0] rsp_rdata_o,
   output logic address_strobe_n_o,
   output logic [29:0] upper_address_lines_o,
   output logic [3:0] byte_enables_n_o,
   output logic space_select_o,
   output logic data_control_select_o,
   output logic direction_select_o,
   output logic lock_n_o,
   input wire logic [31:0] data_lines_i,
   output logic [31:0] data_lines_o,
   output logic data_lines_oe_n_o,
   input wire logic ready_n_i,
   input wire logic next_address_request_n_i,
   input wire logic narrow_width_select_n_i,
   input wire logic hold_request_i,
   output logic hold_grant_o,
   output logic pipeline_entry_o
);

   cnb_state_t st;
   cnb_state_t next_st;
   logic [35:0] pins_s;
   logic rdy;
   logic na_act;
   logic hold_s;
   logic nar_s;
   logic [31:0] din;
   logic ack;
   logic last;
   logic [3:0] left;

   cnb_sync u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .pins_i({ready_n_i, next_address_request_n_i, hold_request_i,
               narrow_width_select_n_i, data_lines_i}),
      .pins_o(pins_s)
   );

   assign rdy = ~pins_s[35];
   assign na_act = ~pins_s[34];
   assign hold_s = pins_s[33];
   assign nar_s = ~pins_s[32];
   assign din = pins_s[31:0];

   function automatic logic [3:0] cyc_def(input cnb_cyc_t t);
      case (t)
         ct_mem_rd: cyc_def = `CNB_DEF_MRD;
         ct_mem_wr: cyc_def = `CNB_DEF_MWR;
         ct_lmem_rd: cyc_def = `CNB_DEF_LMRD;
         ct_lmem_wr: cyc_def = `CNB_DEF_LMWR;
         ct_io_rd: cyc_def = `CNB_DEF_IORD;
         ct_io_wr: cyc_def = `CNB_DEF_IOWR;
         ct_inta: cyc_def = `CNB_DEF_INTA;
         ct_code_rd: cyc_def = `CNB_DEF_CODE;
         default: cyc_def = `CNB_DEF_HALT;
      endcase
   endfunction

   // lanes of the current double word served by one cycle
   function automatic logic [3:0] pick_lanes(input logic [3:0] m, input logic nar);
      if (!nar) begin
         pick_lanes = m;
      end else if (m[1:0] != 2'h0) begin
         pick_lanes = {2'h0, m[1:0]};
      end else begin
         pick_lanes = {m[3:2], 2'h0};
      end
   endfunction

   // enter address state for the next piece of the held operand
   function automatic cnb_state_t launch(input cnb_state_t s, input logic nar);
      cnb_state_t r;
      logic [3:0] l;
      r = s;
      l = pick_lanes(s.msk[3:0], nar);
      r.bs = bs_addr;
      r.ads_n = 1'b0;
      r.nar = nar;
      r.ln = l;
      r.def = cyc_def(s.typ);
      if (s.typ == ct_halt || s.typ == ct_shut) begin
         r.a = `CNB_ADDR_ZERO;
         r.be_n = (s.typ == ct_halt) ? `CNB_HALT_BE_N : `CNB_SHUT_BE_N;
      end else begin
         r.a = s.adr;
         r.be_n = ~l;
      end
      launch = r;
   endfunction

   // write word of the current piece; a narrow upper half is mirrored onto the low lanes
   function automatic logic [31:0] lane_data(input cnb_state_t s);
      logic [31:0] w;
      w = s.sec ? s.wdat[63:32] : s.wdat[31:0];
      lane_data = (s.nar && s.ln[1:0] == 2'h0) ? {w[31:16], w[31:16]} : w;
   endfunction

   assign ack = st.bs == bs_xfer && st.ph && rdy;
   assign left = st.msk[3:0] & ~st.ln;
   assign last = left == 4'h0 && (st.sec || st.msk[7:4] == 4'h0);
   assign req_ready_o = !st.busy || (ack && last);

   always_comb begin
      logic [63:0] sh;
      sh = '0;
      next_st = st;
      next_st.ph = ~st.ph;
      next_st.rsp_v = 1'b0;
      next_st.pipe = 1'b0;
      if (!st.ph) begin
         if (st.wr_hold) begin
            next_st.oe_n = 1'b1;
            next_st.wr_hold = 1'b0;
         end
         if (st.bs == bs_addr && st.def[1]) begin
            next_st.oe_n = 1'b0;
            // loaded here, not at launch, so the previous write keeps its hold time
            next_st.dout = lane_data(st);
         end
         if (st.bs == bs_xfer) begin
            next_st.na_seen = na_act;
         end
      end
      if (ack) begin
         for (int i = 0; i < 4; i++) begin
            if (st.ln[i] && !st.def[1]) begin
               next_st.rdat[(st.sec ? 32 : 0) + 8 * i +: 8] =
                  (st.nar && st.ln[1:0] == 2'h0) ? din[8 * (i & 1) +: 8] : din[8 * i +: 8];
            end
         end
         if (st.def[1]) begin
            next_st.wr_hold = 1'b1;
         end
         next_st.msk[3:0] = left;
         if (last) begin
            sh = next_st.rdat >> {st.off, 3'b000};
            next_st.busy = 1'b0;
            next_st.rsp_v = 1'b1;
            next_st.rsp_d = sh[31:0];
         end else if (left == 4'h0) begin
            next_st.sec = 1'b1;
            next_st.adr = st.adr + 30'h1;
            next_st.msk = {4'h0, st.msk[7:4]};
         end
      end
      if (req_valid_i && req_ready_o) begin
         next_st.busy = 1'b1;
         next_st.typ = req_type_i;
         next_st.off = req_addr_i[1:0];
         next_st.adr = req_addr_i[31:2];
         next_st.sec = 1'b0;
         next_st.rdat = '0;
         next_st.wdat = {32'h0, req_wdata_i} << {req_addr_i[1:0], 3'b000};
         if (req_type_i == ct_halt || req_type_i == ct_shut) begin
            next_st.msk = `CNB_MASK_ONE;
         end else if (req_size_i == sz_byte) begin
            next_st.msk = `CNB_MASK_BYTE << req_addr_i[1:0];
         end else if (req_size_i == sz_word) begin
            next_st.msk = `CNB_MASK_WORD << req_addr_i[1:0];
         end else begin
            next_st.msk = `CNB_MASK_DWORD << req_addr_i[1:0];
         end
      end
      if (st.ph) begin
         case (st.bs)
            bs_idle: begin
               if (hold_s) begin
                  next_st.bs = bs_hold;
                  next_st.grant = 1'b1;
               end else if (next_st.busy) begin
                  next_st = launch(next_st, nar_s);
               end
            end
            bs_hold: begin
               if (!hold_s) begin
                  next_st.bs = bs_idle;
                  next_st.grant = 1'b0;
               end
            end
            bs_addr: begin
               next_st.bs = bs_xfer;
               next_st.ads_n = 1'b1;
            end
            bs_xfer: begin
               if (!rdy) begin
                  next_st.bs = bs_xfer;
                  next_st.pipe = st.na_seen;
               // a write never enters hold directly; it goes to address or idle state for its data hold
               end else if (hold_s && last && !st.def[1]) begin
                  next_st.bs = bs_hold;
                  next_st.grant = 1'b1;
               end else if (next_st.busy) begin
                  next_st = launch(next_st, nar_s);
               end else begin
                  next_st.bs = bs_idle;
               end
            end
            default: begin
               next_st.bs = bs_idle;
            end
         endcase
      end
      if (sys_rst_i) begin
         next_st = '0;
         next_st.bs = bs_idle;
         next_st.typ = ct_mem_rd;
         next_st.ads_n = 1'b1;
         next_st.a = `CNB_RST_ADDR;
         next_st.be_n = `CNB_RST_BE_N;
         next_st.def = `CNB_RST_DEF;
         next_st.oe_n = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   assign rsp_valid_o = st.rsp_v;
   assign rsp_rdata_o = st.rsp_d;
   assign address_strobe_n_o = st.ads_n;
   assign upper_address_lines_o = st.a;
   assign byte_enables_n_o = st.be_n;
   assign space_select_o = st.def[3];
   assign data_control_select_o = st.def[2];
   assign direction_select_o = st.def[1];
   assign lock_n_o = st.def[0];
   assign data_lines_o = st.dout;
   assign data_lines_oe_n_o = st.oe_n;
   assign hold_grant_o = st.grant;
   assign pipeline_entry_o = st.pipe;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   AST_ADS_ONE_STATE: assert property (
      $fell(address_strobe_n_o) |=> !address_strobe_n_o ##1 address_strobe_n_o)
      else $error("address strobe not exactly one bus state");
   AST_NO_EARLY_END: assert property (
      $fell(address_strobe_n_o) |=> !rsp_valid_o [*3])
      else $error("cycle ended inside address state");
   AST_ADDR_TO_XFER: assert property (
      (st.bs == bs_addr && st.ph) |=> st.bs == bs_xfer)
      else $error("address state not followed by transfer state");
   AST_WAIT_REPEAT: assert property (
      (st.bs == bs_xfer && st.ph && !rdy) |=> st.bs == bs_xfer && address_strobe_n_o)
      else $error("wait state not inserted without ready");
   AST_WAIT_STABLE: assert property (
      (st.bs == bs_xfer && $past(st.bs) == bs_xfer) |->
         $stable(upper_address_lines_o) && $stable(byte_enables_n_o) && $stable(st.def))
      else $error("address changed during wait state");
   AST_WR_START: assert property (
      $fell(data_lines_oe_n_o) |-> direction_select_o && $past(st.bs) == bs_addr && st.ph)
      else $error("write data driven at wrong time");
   AST_WR_HOLD: assert property (
      (ack && direction_select_o) |=> !data_lines_oe_n_o)
      else $error("write data released before hold time");
   AST_STATE_PACE: assert property (
      $changed(st.bs) |-> $past(st.ph))
      else $error("bus state changed mid state");
   AST_HALT_BE: assert property (
      (!address_strobe_n_o && st.typ == ct_halt) |->
         byte_enables_n_o == `CNB_HALT_BE_N && upper_address_lines_o == `CNB_ADDR_ZERO)
      else $error("halt cycle address wrong");
   AST_INTA_LOCK: assert property (
      (!address_strobe_n_o && st.typ == ct_inta) |-> !lock_n_o)
      else $error("interrupt acknowledge not locked");
   AST_HOLD_GRANT: assert property (
      $rose(hold_grant_o) |-> $past(hold_s) && address_strobe_n_o && data_lines_oe_n_o)
      else $error("hold granted without request");
   AST_WR_DATA_HOLD: assert property (
      (ack && direction_select_o) |=> $stable(data_lines_o))
      else $error("write data changed inside hold time");
   AST_PIPE_WAIT: assert property (
      pipeline_entry_o |-> st.bs == bs_xfer && !st.ph && address_strobe_n_o)
      else $error("next address acted on outside a wait state");

   COV_READ_FAST: cover property (
      $fell(address_strobe_n_o) ##3 (ack && !direction_select_o));
   COV_WRITE_WAIT: cover property (
      (st.bs == bs_xfer && st.ph && !rdy && direction_select_o) ##2 ack);
   COV_SPLIT: cover property (ack && !last && left == 4'h0);
   COV_HOLD: cover property ($rose(hold_grant_o));

endmodule

`default_nettype wire

// ===== testbench/cnb_sys_model.sv
/*
 behavioural system memory behind the bus sequencer: 16 dwords, ready after a set number of
 wait states, read data on the data lines, write capture by byte enables.
 assumes it is clocked by the double-rate clock and driven at its falling edge.
*/
`timescale 1ns/100ps
`default_nettype none

module cnb_sys_model (
   input wire logic clk_i,
   input wire logic [3:0] waits_i,
   input wire logic strobe_n_i,
   input wire logic [29:0] addr_i,
   input wire logic [3:0] be_n_i,
   input wire logic [3:0] def_i,
   input wire logic [31:0] bus_i,
   input wire logic oe_n_i,
   output logic ready_n_o,
   output logic [31:0] data_o,
   output logic [7:0] err_o
);
   logic [31:0] mem [16];
   logic [31:0] m;
   logic [31:0] wd;
   logic [29:0] ca;
   logic [3:0] cd;
   logic [3:0] cb;
   logic act;
   logic wr_done;
   logic win;
   int cnt;
   int k;

   initial begin
      ready_n_o = 1'b1;
      data_o = 32'h0;
      err_o = 8'h0;
      act = 1'b0;
      wr_done = 1'b0;
      cnt = 0;
      for (int i = 0; i < 16; i++) mem[i] = 32'h0;
   end

   always @(negedge clk_i) begin
      if (wr_done) begin
         if (oe_n_i !== 1'b0 || bus_i !== wd) err_o++;
         wr_done = 1'b0;
      end
      if (!strobe_n_i && (!act || cnt >= k + 3)) begin
         act = 1'b1;
         cnt = 0;
         // wait count is fixed per cycle, a later change applies to the next one
         k = 2 * waits_i;
         ca = addr_i;
         cd = def_i;
         cb = be_n_i;
      end else if (act) begin
         cnt++;
         if (cnt > k + 3) act = 1'b0;
         else if ({addr_i, def_i, be_n_i} !== {ca, cd, cb}) err_o++;
      end
      win = act && cnt >= k + 1 && cnt <= k + 3;
      // slow memory: ready held off for the wait states
      ready_n_o = !win;
      m = mem[ca[3:0]];
      if (win && !cd[1]) begin
         // upper half mirrored onto low lanes for narrow upper accesses
         data_o = {m[31:16], (cb[1:0] == 2'b11) ? m[31:16] : m[15:0]};
         if (oe_n_i === 1'b0) err_o++;
      end else begin
         data_o = ~data_o;
      end
      if (act && cnt == k + 3 && cd[1] && (cd[2] || !cd[3])) begin
         for (int j = 0; j < 4; j++) if (!cb[j]) m[8*j +: 8] = bus_i[8*j +: 8];
         mem[ca[3:0]] = m;
         wd = bus_i;
         wr_done = 1'b1;
      end
   end
endmodule

`default_nettype wire

// ===== testbench/tb_top.sv
/*
 self-checking bench of the bus cycle sequencer: operand requests on the user side, the
 system model on the pins, one task per scenario.
 assumes cnb_bus and cnb_sys_model are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   import cnb_pkg::*;
   logic clk_i = 0, sys_rst_i = 1, rv = 0, narrow_n = 1, hold = 0, na_n = 1;
   cnb_cyc_t rt = ct_mem_rd;
   cnb_size_t rs = sz_dword;
   logic [31:0] ra = 0, rw = 0, rd, dout, sysd, bus;
   logic rr, rsp, ads_n, ss, dc, dir, lk, oe_n, rdy_n, grant, pipe, ps = 1;
   logic [29:0] addr;
   logic [3:0] be_n, waits = 0, l_def, l_be;
   logic [29:0] l_addr;
   logic [7:0] merr;
   logic [3:0] beq[$];
   int num_errors = 0, samples_checked = 0, n_ads = 0, cyc = 0, t_ads = 0, lat, n_pipe = 0;

   initial forever #50 clk_i = ~clk_i;
   assign bus = !oe_n ? dout : sysd;

   cnb_bus cnb_bus_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(rv),
      .req_ready_o(rr), .req_type_i(rt), .req_size_i(rs), .req_addr_i(ra),
      .req_wdata_i(rw), .rsp_valid_o(rsp), .rsp_rdata_o(rd), .address_strobe_n_o(ads_n),
      .upper_address_lines_o(addr), .byte_enables_n_o(be_n), .space_select_o(ss),
      .data_control_select_o(dc), .direction_select_o(dir), .lock_n_o(lk),
      .data_lines_i(bus), .data_lines_o(dout), .data_lines_oe_n_o(oe_n),
      .ready_n_i(rdy_n), .next_address_request_n_i(na_n),
      .narrow_width_select_n_i(narrow_n), .hold_request_i(hold), .hold_grant_o(grant),
      .pipeline_entry_o(pipe));

   cnb_sys_model cnb_sys_model_inst (.clk_i(clk_i), .waits_i(waits), .strobe_n_i(ads_n),
      .addr_i(addr), .be_n_i(be_n), .def_i({ss, dc, dir, lk}), .bus_i(bus),
      .oe_n_i(oe_n), .ready_n_o(rdy_n), .data_o(sysd), .err_o(merr));

   // strobe monitor: counts cycles and records what each strobe presented
   always @(posedge clk_i) begin
      cyc++;
      if (pipe === 1'b1) n_pipe++;
      if (ads_n === 1'b0 && ps === 1'b1) begin
         n_ads++;
         // the strobe was launched at the edge before this one
         t_ads = cyc - 1;
         l_def = {ss, dc, dir, lk};
         l_addr = addr;
         l_be = be_n;
         beq.push_back(be_n);
      end
      ps = ads_n;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic op(input cnb_cyc_t t, input cnb_size_t s, input logic [31:0] a,
         input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(negedge clk_i);
      rv = 1; rt = t; rs = s; ra = a; rw = d;
      while (rr !== 1'b1 && n < 400) begin
         @(negedge clk_i);
         n++;
      end
      @(negedge clk_i);
      rv = 0;
      do begin
         @(posedge clk_i);
         #1 n++;
      end while (rsp !== 1'b1 && n < 800);
      chk("rsp_valid", 1, rsp);
      lat = cyc - t_ads;
      r = rd;
   endtask

   task automatic t_rw;
      logic [31:0] r;
      int a0;
      a0 = n_ads;
      op(ct_mem_wr, sz_dword, 32'h4, 32'h11223344, r);
      chk("def_wr", 4'hf, l_def);
      op(ct_mem_rd, sz_dword, 32'h4, 32'h0, r);
      chk("rd_data", 32'h11223344, r);
      chk("strobes", a0 + 2, n_ads);
      $display("test rw done");
   endtask

   task automatic t_wait;
      logic [31:0] r;
      int p0;
      @(negedge clk_i);
      na_n = 0;
      for (int w = 0; w < 4; w += 3) begin
         waits = 4'(w);
         p0 = n_pipe;
         op(ct_mem_rd, sz_dword, 32'h4, 32'h0, r);
         chk("wait_data", 32'h11223344, r);
         chk("latency", 4 + 2 * w, lat);
         chk("pipe_entry", w, n_pipe - p0);
      end
      waits = 0;
      @(negedge clk_i);
      // next address negated again so later wait states raise no pipeline entry
      na_n = 1;
      $display("test wait done");
   endtask

   task automatic t_split;
      logic [31:0] r;
      int a0;
      beq.delete();
      a0 = n_ads;
      op(ct_mem_wr, sz_dword, 32'h6, 32'haabbccdd, r);
      chk("split_ads", a0 + 2, n_ads);
      chk("be_first", 4'h3, beq[0]);
      chk("be_second", 4'hc, beq[1]);
      op(ct_mem_rd, sz_dword, 32'h6, 32'h0, r);
      chk("split_rd", 32'haabbccdd, r);
      $display("test split done");
   endtask

   task automatic t_narrow;
      logic [31:0] r;
      int a0;
      @(negedge clk_i);
      narrow_n = 0;
      repeat (4) @(negedge clk_i);
      a0 = n_ads;
      op(ct_mem_rd, sz_dword, 32'h4, 32'h0, r);
      chk("narrow_ads", a0 + 2, n_ads);
      chk("narrow_rd", 32'hccdd3344, r);
      @(negedge clk_i);
      narrow_n = 1;
      repeat (4) @(negedge clk_i);
      $display("test narrow done");
   endtask

   task automatic t_types;
      logic [31:0] r;
      logic [3:0] dt [10];
      int a0;
      dt = '{4'hd, 4'hf, 4'hc, 4'he, 4'h5, 4'h7, 4'h0, 4'hb, 4'hb, 4'h9};
      for (int i = 0; i < 10; i++) begin
         op(cnb_cyc_t'(i), sz_byte, 32'h0, 32'h0, r);
         chk("def", dt[i], l_def);
         if (i == 7 || i == 8) begin
            chk("halt_addr", 0, l_addr);
            chk("halt_be", (i == 7) ? 4'hb : 4'he, l_be);
         end
      end
      a0 = n_ads;
      repeat (12) @(negedge clk_i);
      chk("idle", a0, n_ads);
      $display("test types done");
   endtask

   task automatic t_hold;
      int a0, n;
      a0 = n_ads;
      n = 0;
      @(negedge clk_i) hold = 1;
      while (grant !== 1'b1 && n < 20) @(negedge clk_i) n++;
      chk("grant", 1, grant);
      repeat (8) @(negedge clk_i);
      chk("hold_quiet", a0, n_ads);
      hold = 0;
      n = 0;
      while (grant !== 1'b0 && n < 20) @(negedge clk_i) n++;
      chk("release", 0, grant);
      $display("test hold done");
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (4) @(negedge clk_i);
      sys_rst_i = 0;
      repeat (4) @(negedge clk_i);
      t_rw();
      t_wait();
      t_split();
      t_narrow();
      t_types();
      t_hold();
      chk("model_errors", 0, merr);
      final_report();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      final_report();
   end
endmodule

`default_nettype wire
